// ---- common/period_timer_pkg.sv ----
// Package with the register map and field layout of the period timer.
package period_timer_pkg;
   // Register byte addresses on the Wishbone bus.
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_PERIOD = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hC;
   localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h0;
   localparam logic [4:0] ADDR_HI_FLAGS = 5'h10;
   localparam logic [4:0] ADDR_HI_CLEAR = 5'h14;
   // Control register field positions.
   localparam int PRE_LSB = 0;
   localparam int RUN_BIT = 2;
   localparam int POST_LSB = 3;
   localparam int CTRL_WMASK_W = 7;
   // Bit of the period event in the flag, clear and enable registers.
   localparam int EVENT_BIT = 1;
   // Reset values.
   localparam logic [6:0] CONTROL_RST = 7'h00;
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;
   // Prescaler terminal counts for divide by 1, 4 and 16.
   localparam logic [3:0] PRE_TC_1 = 4'h0;
   localparam logic [3:0] PRE_TC_4 = 4'h3;
   localparam logic [3:0] PRE_TC_16 = 4'hF;
   // Instruction clock is one quarter of the bus clock.
   localparam logic [1:0] INSTR_TC = 2'h3;
endpackage

// ---- rtl/period_timer.sv ----
// Eight-bit period timer with prescaler, postscaler and Wishbone registers.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps

// Summary of operation
// - Counts instruction clock, quarter of oscillator
// - Prescale code 00 /1, 01 /4, 1x /16
// - Count continuously compared with period
// - Count rises from zero until period match
// - Increment after match loads zero
// - Each match advances the postscaler
// - Postscale code n gives n+1 matches
// - Postscaler output sets the event flag
// - Count and period readable and writable
// - Reset: count 00h, period FFh
// - Control bit 2 runs or stops timer
// - Count or control write clears scalers
// - Control write leaves count unchanged
// - Unimplemented bits read zero, control resets zero
// - Event flag sticky until software clears
module period_timer
   import period_timer_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o
);

   logic [6:0] control_q;
   logic [7:0] period_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [1:0] instr_q;
   logic [3:0] pre_q;
   logic [3:0] post_q;
   logic flag_q;
   logic enable_q;
   logic [31:0] rdata_d;

   // Bus decode: a request is served once, in the cycle before ack.
   wire req = cyc_i && stb_i && !ack_o;
   wire wr = req && we_i && sel_i[0];
   wire wr_ctrl = wr && adr_i == {1'b0, ADDR_CONTROL};
   wire wr_per = wr && adr_i == {1'b0, ADDR_PERIOD};
   wire wr_cnt = wr && adr_i == {1'b0, ADDR_COUNT};
   wire wr_ien = wr && adr_i == {1'b0, ADDR_IRQ_ENABLE};
   wire wr_clr = wr && adr_i == ADDR_HI_CLEAR;

   // Timing chain: instruction tick, prescaler tick, match, flag event.
   wire run = control_q[RUN_BIT];
   wire [1:0] pre_sel = control_q[PRE_LSB +: 2];
   wire [3:0] post_sel = control_q[POST_LSB +: 4];
   wire instr_tick = run && instr_q == INSTR_TC;
   wire [3:0] pre_tc = pre_sel[1] ? PRE_TC_16 :
                       (pre_sel[0] ? PRE_TC_4 : PRE_TC_1);
   wire pre_tick = instr_tick && pre_q == pre_tc;
   wire match = count_q == period_q;
   wire match_ev = pre_tick && match;
   wire post_ev = match_ev && post_q == post_sel;
   wire scaler_clr = wr_cnt || wr_ctrl;

   // Next count: software write wins, then wrap or increment.
   always_comb begin
      count_d = count_q;
      if (wr_cnt) begin
         count_d = dat_i[7:0];
      end else if (pre_tick) begin
         count_d = match ? COUNT_RST : 8'(count_q + 8'h01);
      end
   end

   // Register read mux; unmapped addresses read zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (adr_i)
         {1'b0, ADDR_CONTROL}: rdata_d = {25'h0, control_q};
         {1'b0, ADDR_PERIOD}: rdata_d = {24'h0, period_q};
         {1'b0, ADDR_COUNT}: rdata_d = {24'h0, count_q};
         {1'b0, ADDR_IRQ_ENABLE}:
            rdata_d = 32'(enable_q) << EVENT_BIT;
         ADDR_HI_FLAGS: rdata_d = 32'(flag_q) << EVENT_BIT;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // Software registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= CONTROL_RST;
         period_q <= PERIOD_RST;
         enable_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            control_q <= dat_i[CTRL_WMASK_W-1:0];
         end
         if (wr_per) begin
            period_q <= dat_i[7:0];
         end
         if (wr_ien) begin
            enable_q <= dat_i[EVENT_BIT];
         end
      end
   end

   // Counter and scalers; count and control writes clear the scalers so a new setting
   // starts from a clean phase rather than mid-division.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= COUNT_RST;
         instr_q <= 2'h0;
         pre_q <= 4'h0;
         post_q <= 4'h0;
      end else begin
         count_q <= count_d;
         instr_q <= run ? 2'(instr_q + 2'h1) : instr_q;
         if (scaler_clr) begin
            pre_q <= 4'h0;
            post_q <= 4'h0;
         end else begin
            if (instr_tick) begin
               pre_q <= pre_tick ? 4'h0 : 4'(pre_q + 4'h1);
            end
            if (match_ev) begin
               post_q <= post_ev ? 4'h0 : 4'(post_q + 4'h1);
            end
         end
      end
   end

   // Sticky flag: a new event beats a clear in the same cycle, so an
   // acknowledge racing a period end never loses the interrupt.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else if (post_ev && !scaler_clr) begin
         flag_q <= 1'b1;
      end else if (wr_clr && dat_i[EVENT_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Bus answer and interrupt, all from flip-flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         irq_o <= 1'b0;
      end else begin
         ack_o <= req;
         dat_o <= req ? rdata_d : 32'h0000_0000;
         irq_o <= (flag_q || (post_ev && !scaler_clr)) &&
                  (wr_ien ? dat_i[EVENT_BIT] : enable_q);
      end
   end

   // Checks of the timing chain and of a control read.
   property p_wrap;
      @(posedge clk_i) disable iff (rst_i)
      (pre_tick && match && !wr_cnt) |=> count_q == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap");

   property p_inc;
      @(posedge clk_i) disable iff (rst_i)
      (pre_tick && !match && !wr_cnt) |=> count_q == $past(count_q) + 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("count did not step");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      (!run && !wr_cnt) |=> count_q == $past(count_q);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped count moved");

   property p_ctrl_keeps;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && !pre_tick) |=> count_q == $past(count_q);
   endproperty
   a_ctrl_keeps: assert property (p_ctrl_keeps) else $error("count lost");

   property p_clr;
      @(posedge clk_i) disable iff (rst_i)
      scaler_clr |=> pre_q == 4'h0 && post_q == 4'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("scalers kept");

   property p_flag_set;
      @(posedge clk_i) disable iff (rst_i)
      (post_ev && !scaler_clr) |=> flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_sticky;
      @(posedge clk_i) disable iff (rst_i)
      (flag_q && !(wr_clr && dat_i[EVENT_BIT])) |=> flag_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

   property p_div1;
      @(posedge clk_i) disable iff (rst_i)
      (instr_tick && pre_sel == 2'h0) |-> pre_tick;
   endproperty
   a_div1: assert property (p_div1) else $error("prescale 1 broken");

   property p_quarter;
      @(posedge clk_i) disable iff (rst_i)
      (instr_tick && run) |=> !instr_tick [*3];
   endproperty
   a_quarter: assert property (p_quarter) else $error("tick too fast");

   property p_rd0;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == {1'b0, ADDR_CONTROL}) |=> !dat_o[7];
   endproperty
   a_rd0: assert property (p_rd0) else $error("bit 7 not zero");

   // Reset loads the documented values whatever was running before.
   property p_rst_vals;
      @(posedge clk_i)
      rst_i |=> count_q == 8'h00 && period_q == 8'hFF && control_q == 7'h00;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values");

   // Reset also silences the bus answer and the interrupt line.
   property p_rst_outs;
      @(posedge clk_i)
      rst_i |=> !ack_o && !irq_o && dat_o == 32'h0000_0000;
   endproperty
   a_rst_outs: assert property (p_rst_outs) else $error("reset outputs");

   // Acknowledge is a single pulse, so a held strobe is served every other cycle.
   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held");

   // Every accepted request is answered in the next cycle.
   property p_ack_next;
      @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");

   // Read data is zero outside the answer cycle.
   property p_dat_idle;
      @(posedge clk_i) disable iff (rst_i)
      !ack_o |-> dat_o == 32'h0000_0000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data not idle");

   // A period write lands on the edge that takes it.
   property p_per_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_per |=> period_q == $past(dat_i[7:0]);
   endproperty
   a_per_wr: assert property (p_per_wr) else $error("period write");

   // A count write beats any increment in the same cycle.
   property p_cnt_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_cnt |=> count_q == $past(dat_i[7:0]);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("count write");

   // A control write stores all seven implemented bits.
   property p_ctrl_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_ctrl |=> control_q == $past(dat_i[6:0]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write");

   // Reading the count returns the value held at the request.
   property p_rd_cnt;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == {1'b0, ADDR_COUNT}) |=>
         dat_o[7:0] == $past(count_q);
   endproperty
   a_rd_cnt: assert property (p_rd_cnt) else $error("count read");

   // Reading the period returns the stored value.
   property p_rd_per;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == {1'b0, ADDR_PERIOD}) |=>
         dat_o[7:0] == $past(period_q);
   endproperty
   a_rd_per: assert property (p_rd_per) else $error("period read");

   // Reading control returns its implemented bits.
   property p_rd_ctrl;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == {1'b0, ADDR_CONTROL}) |=>
         dat_o[6:0] == $past(control_q);
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read");

   // The flag register shows the sticky event bit.
   property p_rd_flag;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == ADDR_HI_FLAGS) |=>
         dat_o[EVENT_BIT] == $past(flag_q);
   endproperty
   a_rd_flag: assert property (p_rd_flag) else $error("flag read");

   // Unmapped addresses read as zero.
   property p_rd_none;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == 5'h18) |=> dat_o == 32'h0000_0000;
   endproperty
   a_rd_none: assert property (p_rd_none) else $error("unmapped read");

   // An enabled, set flag keeps the interrupt line high.
   property p_irq_on;
      @(posedge clk_i) disable iff (rst_i)
      (flag_q && enable_q && !wr_ien) |=> irq_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");

   // A disabled event never reaches the interrupt line.
   property p_irq_off;
      @(posedge clk_i) disable iff (rst_i)
      (!enable_q && !wr_ien) |=> !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq unmasked");

   // The flag only rises after a postscaler output.
   property p_flag_src;
      @(posedge clk_i) disable iff (rst_i)
      $rose(flag_q) |-> $past(post_ev);
   endproperty
   a_flag_src: assert property (p_flag_src) else $error("stray flag");

   // A clear with no competing event drops the flag.
   property p_flag_clr;
      @(posedge clk_i) disable iff (rst_i)
      (wr_clr && dat_i[EVENT_BIT] && !post_ev) |=> !flag_q;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag kept");

   // A stopped timer makes no match events at all.
   property p_stop_quiet;
      @(posedge clk_i) disable iff (rst_i)
      !run |-> !match_ev && !post_ev;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("event");

   // A stopped timer freezes the prescaler phase.
   property p_pre_hold;
      @(posedge clk_i) disable iff (rst_i)
      (!run && !scaler_clr) |=> pre_q == $past(pre_q);
   endproperty
   a_pre_hold: assert property (p_pre_hold) else $error("pre moved");

   // The instruction divider also waits while stopped.
   property p_instr_hold;
      @(posedge clk_i) disable iff (rst_i)
      !run |=> instr_q == $past(instr_q);
   endproperty
   a_instr_hold: assert property (p_instr_hold) else $error("tick moved");

   // The prescaler restarts after each output tick.
   property p_pre_wrap;
      @(posedge clk_i) disable iff (rst_i)
      pre_tick |=> pre_q == 4'h0;
   endproperty
   a_pre_wrap: assert property (p_pre_wrap) else $error("pre no wrap");

   // Divide by four gives no tick before the fourth count.
   property p_div4;
      @(posedge clk_i) disable iff (rst_i)
      (instr_tick && pre_sel == 2'h1 && pre_q != 4'h3) |-> !pre_tick;
   endproperty
   a_div4: assert property (p_div4) else $error("prescale 4 broken");

   // Either upper code divides by sixteen.
   property p_div16;
      @(posedge clk_i) disable iff (rst_i)
      (instr_tick && pre_sel[1] && pre_q != 4'hF) |-> !pre_tick;
   endproperty
   a_div16: assert property (p_div16) else $error("prescale 16 broken");

   // A match below the postscale limit steps the postscaler.
   property p_post_step;
      @(posedge clk_i) disable iff (rst_i)
      (match_ev && !post_ev && !scaler_clr) |=>
         post_q == $past(post_q) + 4'h1;
   endproperty
   a_post_step: assert property (p_post_step) else $error("post step");

   // The postscaler restarts after each output.
   property p_post_wrap;
      @(posedge clk_i) disable iff (rst_i)
      post_ev |=> post_q == 4'h0;
   endproperty
   a_post_wrap: assert property (p_post_wrap) else $error("post no wrap");

   c_wrap: cover property (@(posedge clk_i) disable iff (rst_i) match_ev);
   c_flag: cover property (@(posedge clk_i) disable iff (rst_i) post_ev);
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
   c_race: cover property (@(posedge clk_i) disable iff (rst_i)
      post_ev && wr_clr);
   c_post16: cover property (@(posedge clk_i) disable iff (rst_i)
      post_ev && post_sel == 4'hF);
endmodule

// ---- verif/period_timer_tb_top.sv ----
// Self-checking testbench for the eight-bit period timer.
`timescale 1ns/100ps
module period_timer_tb_top;
   import period_timer_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic irq_o;
   logic [31:0] rd;
   int n_fail = 0;
   int n_checks = 0;
   int cyc_n = 0;
   int t0;
   localparam logic [4:0] A_CTL = {1'b0, ADDR_CONTROL};
   localparam logic [4:0] A_PER = {1'b0, ADDR_PERIOD};
   localparam logic [4:0] A_CNT = {1'b0, ADDR_COUNT};
   localparam logic [4:0] A_IEN = {1'b0, ADDR_IRQ_ENABLE};

   period_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

   // Clock at 25 MHz and a free cycle count for measuring event spacing.
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) cyc_n <= cyc_n + 1;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle; the request is held until ack is sampled high.
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, e);
   endtask

   // Sampled at the falling edge so the registered level has settled.
   task wait_irq;
      do @(negedge clk_i); while (irq_o !== 1'b1);
   endtask

   task t_reset;
      rdchk(A_CTL, 32'h0);
      rdchk(A_PER, 32'hFF);
      rdchk(A_CNT, 32'h0);
      rdchk(A_IEN, 32'h0);
      rdchk(ADDR_HI_FLAGS, 32'h0);
      rdchk(5'h18, 32'h0);
      $display("Test reset values finished");
   endtask

   task t_regs;
      bus(1'b1, A_PER, 8'h5A);
      rdchk(A_PER, 32'h5A);
      bus(1'b1, A_CNT, 8'hA5);
      rdchk(A_CNT, 32'hA5);
      bus(1'b1, A_CTL, 8'hFB);
      rdchk(A_CTL, 32'h7B);
      rdchk(A_CNT, 32'hA5);
      $display("Test register access finished");
   endtask

   // Spacing of two flag events is four clocks times every divider.
   task t_rate(input logic [7:0] ctl, input int exp);
      bus(1'b1, A_PER, 8'h01);
      bus(1'b1, A_IEN, 8'h02);
      bus(1'b1, A_CTL, ctl);
      // Drop a flag left by the previous setting before timing events.
      bus(1'b1, ADDR_HI_CLEAR, 8'h02);
      wait_irq();
      t0 = cyc_n;
      rdchk(ADDR_HI_FLAGS, 32'h2);
      bus(1'b1, ADDR_HI_CLEAR, 8'h02);
      wait_irq();
      chk(cyc_n - t0, exp);
      $display("Test rate %h finished", ctl);
   endtask

   task t_mask;
      bus(1'b1, A_CTL, 8'h00);
      bus(1'b1, A_IEN, 8'h00);
      @(negedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      rdchk(ADDR_HI_FLAGS, 32'h2);
      bus(1'b1, ADDR_HI_CLEAR, 8'h02);
      rdchk(ADDR_HI_FLAGS, 32'h0);
      bus(1'b1, A_CNT, 8'h07);
      repeat (200) @(posedge clk_i);
      rdchk(A_CNT, 32'h7);
      rdchk(ADDR_HI_FLAGS, 32'h0);
      $display("Test mask and stop finished");
   endtask

   task stop_test;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence after twelve cycles of reset.
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_rate(8'h04, 8);
      t_rate(8'h07, 128);
      t_rate(8'h0D, 64);
      t_rate(8'h1E, 512);
      t_rate(8'h7F, 2048);
      t_mask();
      stop_test();
   end

   // The tests need about 6000 cycles; a hang ends the run far later.
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      stop_test();
   end
endmodule
